// ===== core/dsp_pkg.sv
// Shared constants and carriers for the DSP carry, halving and align unit
package dsp_pkg;

    // Instruction encodings
    localparam logic [5:0] MAJOR_GROUP = 6'h00;
    localparam logic [9:0] MINOR_ADD_WC = 10'h3C5;
    localparam logic [9:0] MINOR_ADD_SC = 10'h385;
    localparam logic [10:0] MINOR_HALVE = 11'h14D;
    localparam logic [10:0] MINOR_HALVE_RND = 11'h54D;
    localparam logic [9:0] MINOR_APPEND = 10'h215;
    localparam logic [7:0] SUB_ALIGN = 8'h22;
    localparam logic [9:0] SUB_HALFWORD_BIT_REVERSE = 10'h0C4;
    localparam logic [5:0] EXT_MINOR_GROUP = 6'h3C;

    // Register map, byte offsets within the slave window
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;

    // Field positions and reset values
    localparam int BIT_CARRY = 13;
    localparam int BIT_OUFLAG = 20;
    localparam int BIT_DSP_EN = 0;
    localparam logic RST_CARRY = 1'b0;
    localparam logic RST_OUFLAG = 1'b0;
    localparam logic RST_DSP_EN = 1'b1;

    // Decoded operation
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ADD_WC = 3'b001,
        OP_ADD_SC = 3'b010,
        OP_HALVE = 3'b011,
        OP_HALVE_RND = 3'b100,
        OP_APPEND = 3'b101,
        OP_ALIGN = 3'b110,
        OP_HALFWORD_BIT_REVERSE = 3'b111
    } op_t;

    // Issued instruction with its source operands
    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] rs_val;
        logic [31:0] rt_val;
    } issue_t;

    // Committed result
    typedef struct packed {
        logic done;
        logic wr_en;
        logic [4:0] wr_idx;
        logic [31:0] wr_data;
        logic exc_reserved;
        logic exc_dsp_off;
    } result_t;

endpackage : dsp_pkg

// ===== core/dsp_carry_halve_align_unit.sv
// DSP carry, byte halving, append, align and bit reverse execution unit
//
// Behaviour
// - add_word_with_carry sums sources plus carry bit
// - signed overflow sets sticky flag, else unchanged
// - decode add_word_with_carry fields and register slots
// - only reserved or dsp-disabled exceptions raised
// - byte_halving_add keeps bits 8..1 per byte
// - rounded variant adds one before halving
// - halving adds leave status register untouched
// - append shifts target, fills low source bits
// - byte_align_merge ORs shifted target and source
// - position field bits 15..14, unsigned two bits
// - reverse low halfword, zero upper sixteen bits
// - add_setting_carry stores carry-out at bit 13
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module dsp_carry_halve_align_unit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire dsp_pkg::issue_t iss,
    output dsp_pkg::result_t res
);

    // Bus state
    logic dph_wr_r;
    logic dph_wr_nxt;
    logic [7:0] dph_addr_r;
    logic [7:0] dph_addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic addr_ok;
    // Status and control state
    logic carry_r;
    logic carry_nxt;
    logic ouflag_r;
    logic ouflag_nxt;
    logic dsp_en_r;
    logic dsp_en_nxt;
    logic sw_stat;
    logic sw_ctrl;
    // Datapath
    dsp_pkg::op_t op;
    logic run;
    logic [32:0] wc_sum;
    logic [32:0] sc_sum;
    logic wc_ovf;
    logic [4:0] shamt;
    logic [1:0] bpos;
    logic [31:0] op_data;
    dsp_pkg::result_t res_r;
    dsp_pkg::result_t res_nxt;

    // Instruction decoder
    function automatic dsp_pkg::op_t decode(input logic [31:0] i);
        dsp_pkg::op_t k;
        k = dsp_pkg::OP_NONE;
        if (i[31:26] == dsp_pkg::MAJOR_GROUP) begin
            if (!i[10] && i[9:0] == dsp_pkg::MINOR_ADD_WC) begin
                k = dsp_pkg::OP_ADD_WC;
            end else if (!i[10] && i[9:0] == dsp_pkg::MINOR_ADD_SC) begin
                k = dsp_pkg::OP_ADD_SC;
            end else if (i[10:0] == dsp_pkg::MINOR_HALVE) begin
                k = dsp_pkg::OP_HALVE;
            end else if (i[10:0] == dsp_pkg::MINOR_HALVE_RND) begin
                k = dsp_pkg::OP_HALVE_RND;
            end else if (!i[10] && i[9:0] == dsp_pkg::MINOR_APPEND) begin
                k = dsp_pkg::OP_APPEND;
            end else if (i[13:6] == dsp_pkg::SUB_ALIGN &&
                         i[5:0] == dsp_pkg::EXT_MINOR_GROUP) begin
                k = dsp_pkg::OP_ALIGN;
            end else if (i[15:6] == dsp_pkg::SUB_HALFWORD_BIT_REVERSE &&
                         i[5:0] == dsp_pkg::EXT_MINOR_GROUP) begin
                k = dsp_pkg::OP_HALFWORD_BIT_REVERSE;
            end
        end
        return k;
    endfunction : decode

    // Four byte lanes, each a 9-bit sum halved
    function automatic logic [31:0] halve_bytes(input logic [31:0] a,
                                                input logic [31:0] b,
                                                input logic rnd);
        logic [31:0] w;
        logic [8:0] s;
        w = '0;
        for (int n = 0; n < 4; n++) begin
            s = {1'b0, a[8*n +: 8]} + {1'b0, b[8*n +: 8]} + {8'h00, rnd};
            w[8*n +: 8] = s[8:1];
        end
        return w;
    endfunction : halve_bytes

    // Status word image as software sees it
    function automatic logic [31:0] stat_word(input logic c, input logic o);
        logic [31:0] w;
        w = '0;
        w[dsp_pkg::BIT_CARRY] = c;
        w[dsp_pkg::BIT_OUFLAG] = o;
        return w;
    endfunction : stat_word

    // Operation results
    always_comb begin
        op = decode(iss.instr);
        run = iss.valid && op != dsp_pkg::OP_NONE && dsp_en_r;
        wc_sum = {iss.rs_val[31], iss.rs_val} + {iss.rt_val[31], iss.rt_val}
                 + {32'h00000000, carry_r};
        wc_ovf = wc_sum[32] != wc_sum[31];
        sc_sum = {1'b0, iss.rs_val} + {1'b0, iss.rt_val};
        shamt = iss.instr[15:11];
        bpos = iss.instr[15:14];
        case (op)
            dsp_pkg::OP_ADD_WC: op_data = wc_sum[31:0];
            dsp_pkg::OP_ADD_SC: op_data = sc_sum[31:0];
            dsp_pkg::OP_HALVE: op_data = halve_bytes(iss.rs_val, iss.rt_val,
                                                     1'b0);
            dsp_pkg::OP_HALVE_RND: op_data = halve_bytes(iss.rs_val,
                                                         iss.rt_val, 1'b1);
            // Zero amount leaves the target as it was
            dsp_pkg::OP_APPEND: op_data = (iss.rt_val << shamt) |
                (iss.rs_val & ~(32'hFFFFFFFF << shamt));
            // Position 0 gives the target, 2 is undefined anyway
            dsp_pkg::OP_ALIGN: op_data = (iss.rt_val << {bpos, 3'b000}) |
                (iss.rs_val >> {3'd4 - {1'b0, bpos}, 3'b000});
            dsp_pkg::OP_HALFWORD_BIT_REVERSE: begin
                op_data = '0;
                for (int n = 0; n < 16; n++) begin
                    op_data[n] = iss.rs_val[15 - n];
                end
            end
            default: op_data = '0;
        endcase
    end

    // Result next value; only decode and enable can raise exceptions
    always_comb begin
        res_nxt = '0;
        res_nxt.done = iss.valid;
        if (iss.valid) begin
            if (op == dsp_pkg::OP_NONE) begin
                res_nxt.exc_reserved = 1'b1;
            end else if (!dsp_en_r) begin
                res_nxt.exc_dsp_off = 1'b1;
            end else begin
                res_nxt.wr_en = 1'b1;
                res_nxt.wr_data = op_data;
                case (op)
                    dsp_pkg::OP_ADD_WC, dsp_pkg::OP_ADD_SC,
                    dsp_pkg::OP_HALVE, dsp_pkg::OP_HALVE_RND:
                        res_nxt.wr_idx = iss.instr[15:11];
                    default: res_nxt.wr_idx = iss.instr[25:21];
                endcase
            end
        end
    end

    // Result register, commits with the flag update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // Status and control; hardware updates win over a software write
    always_comb begin
        sw_stat = dph_wr_r && dph_addr_r == dsp_pkg::OFS_STATUS;
        sw_ctrl = dph_wr_r && dph_addr_r == dsp_pkg::OFS_CTRL;
        carry_nxt = carry_r;
        ouflag_nxt = ouflag_r;
        dsp_en_nxt = dsp_en_r;
        if (sw_stat) begin
            carry_nxt = hwdata[dsp_pkg::BIT_CARRY];
            ouflag_nxt = hwdata[dsp_pkg::BIT_OUFLAG];
        end
        if (sw_ctrl) begin
            dsp_en_nxt = hwdata[dsp_pkg::BIT_DSP_EN];
        end
        if (run && op == dsp_pkg::OP_ADD_SC) begin
            carry_nxt = sc_sum[32];
        end
        if (run && op == dsp_pkg::OP_ADD_WC && wc_ovf) begin
            ouflag_nxt = 1'b1;
        end
    end

    // Status and control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carry_r <= dsp_pkg::RST_CARRY;
            ouflag_r <= dsp_pkg::RST_OUFLAG;
            dsp_en_r <= dsp_pkg::RST_DSP_EN;
        end else begin
            carry_r <= carry_nxt;
            ouflag_r <= ouflag_nxt;
            dsp_en_r <= dsp_en_nxt;
        end
    end

    // Bus slave: zero wait states, read data from next-state values
    always_comb begin
        addr_ok = hsel && hready && htrans[1];
        dph_wr_nxt = addr_ok && hwrite;
        dph_addr_nxt = addr_ok ? haddr[dsp_pkg::ADDR_W-1:0] : dph_addr_r;
        hrdata_nxt = hrdata_r;
        if (addr_ok && !hwrite) begin
            case (haddr[dsp_pkg::ADDR_W-1:0])
                dsp_pkg::OFS_STATUS: hrdata_nxt = stat_word(carry_nxt,
                                                            ouflag_nxt);
                dsp_pkg::OFS_CTRL: hrdata_nxt = {31'h00000000, dsp_en_nxt};
                default: hrdata_nxt = '0;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= '0;
            hrdata_r <= '0;
        end else begin
            dph_wr_r <= dph_wr_nxt;
            dph_addr_r <= dph_addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // Constant ready and OKAY, still from flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign res = res_r;

    // Checks
    logic [32:0] chk_wc;
    logic [32:0] chk_sc;
    logic [8:0] chk_b0;
    logic [8:0] chk_b3;
    assign chk_wc = {iss.rs_val[31], iss.rs_val} +
                    {iss.rt_val[31], iss.rt_val} + {32'h00000000, carry_r};
    assign chk_sc = {1'b0, iss.rs_val} + {1'b0, iss.rt_val};
    assign chk_b0 = {1'b0, iss.rs_val[7:0]} + {1'b0, iss.rt_val[7:0]};
    assign chk_b3 = {1'b0, iss.rs_val[31:24]} + {1'b0, iss.rt_val[31:24]}
                    + 9'h001;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_run(dsp_pkg::op_t k);
        iss.valid && op == k && dsp_en_r;
    endsequence

    sequence s_quiet;
        !sw_stat;
    endsequence

    property p_add_wc_sum;
        s_run(dsp_pkg::OP_ADD_WC) |=>
            res.wr_en && res.wr_data == $past(chk_wc[31:0]);
    endproperty
    a_add_wc_sum: assert property (p_add_wc_sum)
        else $error("carry add result wrong");

    property p_ovf_set;
        s_run(dsp_pkg::OP_ADD_WC) ##0 (chk_wc[32] != chk_wc[31]) |=>
            ouflag_r;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set");

    property p_ovf_keep;
        s_run(dsp_pkg::OP_ADD_WC) ##0 (chk_wc[32] == chk_wc[31]) ##0
            s_quiet |=> ouflag_r == $past(ouflag_r);
    endproperty
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow flag changed without overflow");

    property p_dest_field;
        s_run(dsp_pkg::OP_ADD_WC) |=>
            res.wr_idx == $past(iss.instr[15:11]) && !res.exc_reserved;
    endproperty
    a_dest_field: assert property (p_dest_field)
        else $error("carry add destination wrong");

    property p_no_data_exc;
        iss.valid && op != dsp_pkg::OP_NONE |=>
            !res.exc_reserved && res.exc_dsp_off == !$past(dsp_en_r);
    endproperty
    a_no_data_exc: assert property (p_no_data_exc)
        else $error("unexpected exception");

    property p_halve;
        s_run(dsp_pkg::OP_HALVE) |=> res.wr_data[7:0] == $past(chk_b0[8:1]);
    endproperty
    a_halve: assert property (p_halve)
        else $error("halving add byte wrong");

    property p_halve_rnd;
        s_run(dsp_pkg::OP_HALVE_RND) |=>
            res.wr_data[31:24] == $past(chk_b3[8:1]);
    endproperty
    a_halve_rnd: assert property (p_halve_rnd)
        else $error("rounded halving add byte wrong");

    property p_halve_status;
        (s_run(dsp_pkg::OP_HALVE) or s_run(dsp_pkg::OP_HALVE_RND)) ##0
            s_quiet |=> $stable(carry_r) && $stable(ouflag_r);
    endproperty
    a_halve_status: assert property (p_halve_status)
        else $error("halving add touched status");

    property p_append_zero;
        s_run(dsp_pkg::OP_APPEND) ##0 (iss.instr[15:11] == 5'h00) |=>
            res.wr_data == $past(iss.rt_val);
    endproperty
    a_append_zero: assert property (p_append_zero)
        else $error("append by zero changed target");

    property p_align_one;
        s_run(dsp_pkg::OP_ALIGN) ##0 (iss.instr[15:14] == 2'h1) |=>
            res.wr_data == {$past(iss.rt_val[23:0]), $past(iss.rs_val[31:24])};
    endproperty
    a_align_one: assert property (p_align_one)
        else $error("byte align result wrong");

    property p_halfword_bit_reverse;
        s_run(dsp_pkg::OP_HALFWORD_BIT_REVERSE) |=> res.wr_data[31:16] == 16'h0000 &&
            res.wr_data[0] == $past(iss.rs_val[15]) &&
            res.wr_idx == $past(iss.instr[25:21]);
    endproperty
    a_halfword_bit_reverse: assert property (p_halfword_bit_reverse)
        else $error("bit reverse result wrong");

    property p_carry_set;
        s_run(dsp_pkg::OP_ADD_SC) |=>
            carry_r == $past(chk_sc[32]) && res.wr_en &&
            res.wr_data == $past(chk_sc[31:0]);
    endproperty
    a_carry_set: assert property (p_carry_set)
        else $error("carry flag not stored with result");

endmodule : dsp_carry_halve_align_unit

// ===== verification/dsp_issue_model.sv
// Decode-stage stand-in that issues instructions to the unit
`timescale 1ns/1ps

module dsp_issue_model (
    input wire logic hclk,
    output dsp_pkg::issue_t iss
);

    // Quiet until the first instruction
    initial begin
        iss = '0;
    end

    // One instruction per edge, held until the taking edge
    task automatic issue(input logic [31:0] ins, input logic [31:0] rs_v,
                         input logic [31:0] rt_v);
        iss <= {1'b1, ins, rs_v, rt_v};
        @(posedge hclk);
    endtask : issue

    // Drop valid and scramble the stale operand lines
    task automatic stop();
        iss <= {1'b0, ~iss.instr, ~iss.rs_val, ~iss.rt_val};
    endtask : stop

endmodule : dsp_issue_model

// ===== verification/dsp_carry_halve_align_unit_tb.sv
// Self-checking bench for the DSP carry, halving and align unit
`timescale 1ns/1ps

module dsp_carry_halve_align_unit_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    dsp_pkg::issue_t iss;
    dsp_pkg::result_t res;
    dsp_pkg::result_t exp_q[$];
    dsp_pkg::result_t e_m;
    dsp_pkg::result_t g_m;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h5E;
    logic carry_m = dsp_pkg::RST_CARRY;
    logic ouf_m = dsp_pkg::RST_OUFLAG;
    logic en_m = dsp_pkg::RST_DSP_EN;
    logic [31:0] rd_v;

    // Free-running bus clock
    always #20 hclk = ~hclk;

    dsp_carry_halve_align_unit dut_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .iss(iss),
        .res(res)
    );

    dsp_issue_model pm_u (
        .hclk(hclk),
        .iss(iss)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Status word as the flags should stand
    function automatic logic [31:0] stat();
        stat = {11'h0, ouf_m, 6'h0, carry_m, 13'h0};
    endfunction : stat

    task automatic wrap_up();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_res(input dsp_pkg::result_t got,
                           input dsp_pkg::result_t exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_res

    // Single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
        chk_word({31'h0, hresp}, 32'h0);
    endtask : ahb

    // Build one instruction, note its result, issue it
    task automatic run(input int k, input logic [4:0] f,
                       input logic [31:0] a, input logic [31:0] b);
        logic [4:0] rt;
        logic [4:0] rd;
        logic [32:0] s;
        logic [31:0] ins;
        dsp_pkg::result_t e;
        rt = seed[25:21];
        rd = seed[15:11];
        e = '0;
        e.done = 1'b1;
        e.wr_en = 1'b1;
        e.wr_idx = rd;
        ins = {dsp_pkg::MAJOR_GROUP, rt, 5'h01, rd, 11'h000};
        case (k)
            0: begin
                ins[10:0] = {1'b0, dsp_pkg::MINOR_ADD_WC};
                s = {a[31], a} + {b[31], b} + {32'h0, carry_m};
                e.wr_data = s[31:0];
                ouf_m = ouf_m | (en_m & (s[32] ^ s[31]));
            end
            1: begin
                ins[10:0] = {1'b0, dsp_pkg::MINOR_ADD_SC};
                s = {1'b0, a} + {1'b0, b};
                e.wr_data = s[31:0];
                carry_m = en_m ? s[32] : carry_m;
            end
            2, 3: begin
                ins[10:0] = (k == 3) ? dsp_pkg::MINOR_HALVE_RND
                                     : dsp_pkg::MINOR_HALVE;
                for (int i = 0; i < 4; i++) begin
                    s[8:0] = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]}
                             + 9'(k == 3);
                    e.wr_data[8*i+:8] = s[8:1];
                end
            end
            4: begin
                ins[15:0] = {f, 1'b0, dsp_pkg::MINOR_APPEND};
                e.wr_idx = rt;
                e.wr_data = (b << f) | (a & ((32'h1 << f) - 32'h1));
            end
            5: begin
                ins[15:0] = {f[1], 1'b1, dsp_pkg::SUB_ALIGN,
                             dsp_pkg::EXT_MINOR_GROUP};
                e.wr_idx = rt;
                e.wr_data = (b << (16 * f[1] + 8)) | (a >> (24 - 16 * f[1]));
            end
            6: begin
                ins[15:0] = {dsp_pkg::SUB_HALFWORD_BIT_REVERSE, dsp_pkg::EXT_MINOR_GROUP};
                e.wr_idx = rt;
                for (int i = 0; i < 16; i++) e.wr_data[i] = a[15 - i];
            end
            default: begin
                e.wr_en = 1'b0;
                e.exc_reserved = 1'b1;
            end
        endcase
        if (!en_m && k < 7) begin
            e.wr_en = 1'b0;
            e.exc_dsp_off = 1'b1;
        end
        exp_q.push_back(e);
        pm_u.issue(ins, a, b);
    endtask : run

    // Pair each committed result with the oldest note
    always @(negedge hclk) begin
        if (res.done === 1'b1) begin
            e_m = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            g_m = res;
            if (!e_m.wr_en) begin
                g_m.wr_idx = e_m.wr_idx;
                g_m.wr_data = e_m.wr_data;
            end
            chk_res(g_m, e_m);
        end
    end

    // Hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd_v, stat());
        ahb(1'b0, 32'h4, 32'h0);
        chk_word(rd_v, {31'h0, dsp_pkg::RST_DSP_EN});
        ahb(1'b1, 32'h8, 32'hFFFFFFFF);
        ahb(1'b0, 32'h8, 32'h0);
        chk_word(rd_v, 32'h0);
        run(1, 5'h00, 32'hFFFFFFFF, 32'h00000001);
        run(0, 5'h00, 32'h7FFFFFFF, 32'h00000000);
        run(0, 5'h00, 32'h12345678, 32'h0F0F0F0F);
        run(2, 5'h00, 32'hFF01FF00, 32'hFF00FF01);
        run(3, 5'h00, 32'hFF01FF00, 32'hFF00FF01);
        run(4, 5'h00, 32'hA5A5A5A5, 32'h3C3C3C3C);
        run(4, 5'h1F, 32'hA5A5A5A5, 32'h3C3C3C3C);
        run(5, 5'h01, 32'h11223344, 32'h55667788);
        run(5, 5'h03, 32'h11223344, 32'h55667788);
        run(6, 5'h00, 32'hFFFF8003, 32'h00000000);
        run(7, 5'h00, 32'h0, 32'h0);
        for (int n = 0; n < 48; n++) begin
            seed = lfsr(seed);
            run(n % 8, seed[9:5], seed, lfsr(seed));
            seed = lfsr(seed);
        end
        pm_u.stop();
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd_v, stat());
        ahb(1'b1, 32'h4, 32'h0);
        en_m = 1'b0;
        run(0, 5'h00, 32'h7FFFFFFF, 32'h7FFFFFFF);
        run(1, 5'h00, 32'h0, 32'h0);
        run(7, 5'h00, 32'h0, 32'h0);
        pm_u.stop();
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd_v, stat());
        ahb(1'b1, 32'h4, 32'h1);
        en_m = 1'b1;
        ahb(1'b1, 32'h0, 32'h0);
        carry_m = 1'b0;
        ouf_m = 1'b0;
        ahb(1'b0, 32'h0, 32'h0);
        chk_word(rd_v, stat());
        repeat (2) @(posedge hclk);
        chk_word(32'(exp_q.size()), 32'h0);
        wrap_up();
    end

endmodule : dsp_carry_halve_align_unit_tb
